// file: fmhi_pkg.sv
// constants and carrier types for the fax modem host interface
package fmhi_pkg;
   // ----------------------------------------
   // bus geometry
   // ----------------------------------------
   localparam int DATA_W = 8;
   localparam int ADDR_W = 5;
   localparam int REG_COUNT = 32;
   localparam int BITS_PER_BYTE = 8;
   localparam int FIFO_DEPTH = 32;

   // ----------------------------------------
   // interface memory map
   // ----------------------------------------
   localparam logic [4:0] REG_TX_BUF = 5'h00;
   localparam logic [4:0] REG_RX_BUF = 5'h01;
   localparam logic [4:0] REG_CONTROL = 5'h02;
   localparam logic [4:0] REG_IRQ_ENABLE = 5'h03;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_CHANGE = 5'h05;
   localparam logic [4:0] REG_BUF_STATE = 5'h06;
   localparam int CTRL_PDM_BIT = 0;
   localparam int BUF_TX_FULL_BIT = 0;
   localparam int BUF_RX_AVAIL_BIT = 1;
   localparam int BUF_READY_BIT = 2;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic RX_IDLE_LEVEL = 1'b1;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int POR_LOW_MS = 350;
   localparam int READY_MS = 15;
   localparam int READY_CYCLES_DEF = READY_MS * 1000000 / CLK_PERIOD_NS;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic sel;
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [7:0] data;
   } bus_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } byte_xfer_t;
endpackage

// file: fmhi_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module fmhi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [PW:0] count, next_count;
   logic push, pop;

   always_comb begin
      push = in_valid_in && (count != PW'(0) + (PW+1)'(DEPTH));
      pop = out_ready_in && (count != '0);
      next_wr_ptr = push ? ((wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count = count + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   // flags follow the registered count, honest every cycle
   assign in_ready_out = (count != (PW+1)'(DEPTH));
   assign out_valid_out = (count != '0);
   assign out_data_out = mem[rd_ptr];
endmodule

// file: fax_modem_host_interface.sv
// host bus, serial data port and interrupt logic of the fax modem
// Contract
// - with chip select active, five select lines (top one msb) pick one of 32 registers
// - eight-bit two-way data bus, highest line is msb
// - data bus floats whenever no read or write is in progress
// - register data moves only while host holds chip select active
// - strap low: read pin is read strobe, write pin is write strobe
// - strap high: read pin is phase-two clock, write pin is read/write line
// - interrupt only when its enable is set and selected status change occurs
// - interrupt output only pulls low, else floats on external pull-up
// - serial mode: sample transmit input on bit clock rising edge
// - parallel mode: ignore serial input, take bytes written to transmit buffer
// - received data appears on serial output in both data modes
// - serial receive output changes on bit clock falling edge
// - power-on reset held low about 350 ms; ready 15 ms after it rises
`timescale 1ns/1ps
module fax_modem_host_interface
   import fmhi_pkg::*;
#(
   parameter int READY_CYCLES = fmhi_pkg::READY_CYCLES_DEF,
   parameter int TX_FIFO_DEPTH = fmhi_pkg::FIFO_DEPTH
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic power_on_reset_n_in,
   input wire logic bus_style_strap_in,
   input wire logic chip_select_n_in,
   input wire logic read_pin_in,
   input wire logic write_pin_in,
   input wire logic [fmhi_pkg::ADDR_W-1:0] register_select_lines_in,
   input wire logic [fmhi_pkg::DATA_W-1:0] host_data_lines_in,
   output logic [fmhi_pkg::DATA_W-1:0] host_data_lines_out,
   output logic host_data_lines_oe_n_out,
   output logic irq_n_out,
   output logic irq_oe_n_out,
   input wire logic bit_clock_in,
   input wire logic serial_tx_input_in,
   output logic serial_rx_output_out,
   input wire logic [fmhi_pkg::DATA_W-1:0] modem_status_in,
   output logic [fmhi_pkg::DATA_W-1:0] tx_data_out,
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   input wire logic [fmhi_pkg::DATA_W-1:0] rx_data_in,
   input wire logic rx_valid_in,
   output logic rx_ready_out,
   output logic ready_out
);
   import fmhi_pkg::*;

   // ----------------------------------------
   // reset and bus decode
   // ----------------------------------------
   logic rst;
   bus_req_t req;
   assign rst = rst_in || !power_on_reset_n_in;

   always_comb begin
      req.sel = !chip_select_n_in;
      if (bus_style_strap_in) begin
         req.rd = req.sel && read_pin_in && write_pin_in;
         req.wr = req.sel && read_pin_in && !write_pin_in;
      end else begin
         req.rd = req.sel && !read_pin_in;
         req.wr = req.sel && !write_pin_in;
      end
      req.addr = register_select_lines_in;
      req.data = host_data_lines_in;
   end

   // ----------------------------------------
   // interface memory and bus answer
   // ----------------------------------------
   logic [7:0] regs [REG_COUNT];
   logic [7:0] next_regs [REG_COUNT];
   bus_req_t wr_hold, rd_hold, next_wr_hold, next_rd_hold;
   logic [7:0] next_dout;
   logic commit, rd_done, pdm;
   logic [7:0] change, status_q, rx_hold;
   logic rx_avail, tx_full, push_ready;
   byte_xfer_t push, next_push;

   assign pdm = regs[REG_CONTROL][CTRL_PDM_BIT];
   // data is taken as the strobe ends, when the host has surely settled it
   assign commit = wr_hold.wr && !req.wr;
   assign rd_done = rd_hold.rd && !req.rd;

   always_comb begin
      next_regs = regs;
      next_wr_hold = req.wr ? req : wr_hold;
      next_wr_hold.wr = req.wr;
      next_rd_hold = req;
      if (commit && wr_hold.addr != REG_RX_BUF && wr_hold.addr != REG_STATUS
          && wr_hold.addr != REG_CHANGE && wr_hold.addr != REG_BUF_STATE) begin
         next_regs[wr_hold.addr] = wr_hold.data;
      end
      unique case (req.addr)
         REG_RX_BUF: next_dout = rx_hold;
         REG_STATUS: next_dout = status_q;
         REG_CHANGE: next_dout = change;
         REG_BUF_STATE: begin
            next_dout = 8'h00;
            next_dout[BUF_TX_FULL_BIT] = tx_full;
            next_dout[BUF_RX_AVAIL_BIT] = rx_avail;
            next_dout[BUF_READY_BIT] = ready_out;
         end
         default: next_dout = regs[req.addr];
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regs[i] <= REG_RESET;
         end
         wr_hold <= '0;
         rd_hold <= '0;
         host_data_lines_out <= 8'h00;
         host_data_lines_oe_n_out <= 1'b1;
      end else begin
         regs <= next_regs;
         wr_hold <= next_wr_hold;
         rd_hold <= next_rd_hold;
         host_data_lines_out <= next_dout;
         host_data_lines_oe_n_out <= !req.rd;
      end
   end

   // ----------------------------------------
   // transmit path
   // ----------------------------------------
   logic bclk_q, bclk_rise, bclk_fall;
   logic [7:0] tx_shift, next_tx_shift;
   logic [2:0] tx_cnt, next_tx_cnt;

   assign bclk_rise = bit_clock_in && !bclk_q;
   assign bclk_fall = !bit_clock_in && bclk_q;

   // a byte finished while the previous one still waits for room is lost;
   // software watches the full flag to avoid it
   always_comb begin
      next_tx_shift = tx_shift;
      next_tx_cnt = tx_cnt;
      next_push = push;
      if (push.valid && push_ready) begin
         next_push.valid = 1'b0;
      end
      if (!pdm && bclk_rise) begin
         next_tx_shift = {serial_tx_input_in, tx_shift[7:1]};
         next_tx_cnt = tx_cnt + 3'h1;
         if (tx_cnt == 3'(BITS_PER_BYTE - 1) && !push.valid) begin
            next_push.valid = 1'b1;
            next_push.data = {serial_tx_input_in, tx_shift[7:1]};
         end
      end
      if (pdm && commit && wr_hold.addr == REG_TX_BUF && !push.valid) begin
         next_push.valid = 1'b1;
         next_push.data = wr_hold.data;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      // tracks the pin through reset too, so release never shows a false edge
      bclk_q <= bit_clock_in;
      if (rst) begin
         tx_shift <= 8'h00;
         tx_cnt <= 3'h0;
         push <= '0;
         tx_full <= 1'b0;
      end else begin
         tx_shift <= next_tx_shift;
         tx_cnt <= next_tx_cnt;
         push <= next_push;
         tx_full <= !push_ready;
      end
   end

   fmhi_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst),
      .in_valid_in(push.valid),
      .in_ready_out(push_ready),
      .in_data_in(push.data),
      .out_valid_out(tx_valid_out),
      .out_ready_in(tx_ready_in),
      .out_data_out(tx_data_out)
   );

   // ----------------------------------------
   // receive path
   // ----------------------------------------
   logic [7:0] rx_shift, next_rx_shift, next_rx_hold;
   logic [3:0] rx_cnt, next_rx_cnt;
   logic next_rxd, next_rx_avail;

   always_comb begin
      next_rx_shift = rx_shift;
      next_rx_cnt = rx_cnt;
      next_rx_hold = rx_hold;
      next_rxd = serial_rx_output_out;
      next_rx_avail = rx_avail;
      if (rd_done && rd_hold.addr == REG_RX_BUF) begin
         next_rx_avail = 1'b0;
      end
      if (bclk_fall) begin
         if (rx_cnt != 4'h0) begin
            next_rxd = rx_shift[0];
            next_rx_shift = {1'b0, rx_shift[7:1]};
            next_rx_cnt = rx_cnt - 4'h1;
         end else begin
            next_rxd = RX_IDLE_LEVEL;
         end
      end
      if (rx_valid_in && rx_ready_out) begin
         next_rx_shift = rx_data_in;
         next_rx_cnt = 4'(BITS_PER_BYTE);
         next_rx_hold = rx_data_in;
         next_rx_avail = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst) begin
         rx_shift <= 8'h00;
         rx_cnt <= 4'h0;
         rx_hold <= 8'h00;
         rx_avail <= 1'b0;
         serial_rx_output_out <= RX_IDLE_LEVEL;
         rx_ready_out <= 1'b0;
      end else begin
         rx_shift <= next_rx_shift;
         rx_cnt <= next_rx_cnt;
         rx_hold <= next_rx_hold;
         rx_avail <= next_rx_avail;
         serial_rx_output_out <= next_rxd;
         rx_ready_out <= (next_rx_cnt == 4'h0);
      end
   end

   // ----------------------------------------
   // status change, interrupt and readiness
   // ----------------------------------------
   logic [7:0] next_change;
   logic [31:0] ready_cnt, next_ready_cnt;

   always_comb begin
      next_change = change;
      if (commit && wr_hold.addr == REG_CHANGE) begin
         next_change = change & ~wr_hold.data;
      end
      // a change landing in the clearing cycle survives
      next_change = next_change | (modem_status_in ^ status_q);
      next_ready_cnt = ready_cnt;
      if (ready_cnt != 32'(READY_CYCLES)) begin
         next_ready_cnt = ready_cnt + 32'h1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst) begin
         status_q <= 8'h00;
         change <= 8'h00;
         irq_n_out <= 1'b0;
         irq_oe_n_out <= 1'b1;
         ready_cnt <= 32'h0;
         ready_out <= 1'b0;
      end else begin
         status_q <= modem_status_in;
         change <= next_change;
         irq_n_out <= 1'b0;
         irq_oe_n_out <= !(|(change & regs[REG_IRQ_ENABLE]));
         ready_cnt <= next_ready_cnt;
         ready_out <= (next_ready_cnt == 32'(READY_CYCLES));
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst);

   sequence seq_write_end;
      wr_hold.wr && !req.wr;
   endsequence
   sequence seq_serial_bit;
      !pdm && bclk_rise;
   endsequence

   AST_READ_DRIVES: assert property (req.rd |=> !host_data_lines_oe_n_out)
      else $error("read did not drive the data bus");
   AST_NO_SELECT_FLOAT: assert property (!req.sel |=> host_data_lines_oe_n_out)
      else $error("data bus driven without chip select");
   AST_DECODE_WRITE: assert property ((seq_write_end and wr_hold.addr == REG_IRQ_ENABLE)
      |=> regs[REG_IRQ_ENABLE] == $past(wr_hold.data))
      else $error("write to enable register not stored");
   AST_STRAP_LOW_READ: assert property ((!bus_style_strap_in && !chip_select_n_in
      && !read_pin_in) |=> !host_data_lines_oe_n_out)
      else $error("read strobe ignored in strobe style");
   AST_STRAP_HIGH_WRITE: assert property ((bus_style_strap_in && !chip_select_n_in
      && read_pin_in && !write_pin_in) |=> host_data_lines_oe_n_out)
      else $error("bus driven during phase-two write");
   AST_IRQ_CAUSE: assert property (!irq_oe_n_out
      |-> $past(|(change & regs[REG_IRQ_ENABLE])))
      else $error("interrupt without enabled change");
   AST_IRQ_PULL_ONLY: assert property (irq_n_out == 1'b0)
      else $error("interrupt line driven high");
   AST_TX_SAMPLE: assert property (seq_serial_bit
      |=> tx_shift[7] == $past(serial_tx_input_in))
      else $error("serial transmit bit not sampled");
   AST_TX_PARALLEL_IGNORE: assert property ((pdm && bclk_rise)
      |=> tx_shift == $past(tx_shift))
      else $error("serial input used in parallel mode");
   AST_RX_SHIFT: assert property ((bclk_fall && rx_cnt != 4'h0)
      |=> serial_rx_output_out == $past(rx_shift[0]))
      else $error("receive bit not presented");
   AST_RX_FALL_ONLY: assert property ($changed(serial_rx_output_out)
      |-> ($past(bclk_fall) || $past(rst)))
      else $error("receive output changed off a falling edge");
   AST_READY_TIME: assert property ($rose(ready_out)
      |-> $past(ready_cnt) == 32'(READY_CYCLES - 1))
      else $error("ready raised at wrong time");
endmodule

// file: fmhi_terminal.sv
// serial data terminal model: makes the bit clock and swaps one byte each way
`timescale 1ns/1ps
module fmhi_terminal (
   input wire logic sys_clk_in,
   input wire logic serial_rx_output_in,
   output logic bit_clock_out,
   output logic serial_tx_input_out
);
   localparam int HALF = 4;

   // clock stands high between frames, so the first bit of a frame starts with a fall
   initial begin
      bit_clock_out = 1'b1;
      serial_tx_input_out = 1'b0;
   end

   task automatic frame(input logic [7:0] tx_byte, output logic [7:0] rx_byte);
      for (int i = 0; i < 8; i++) begin
         @(negedge sys_clk_in);
         bit_clock_out = 1'b0;
         serial_tx_input_out = tx_byte[i];
         repeat (HALF) @(negedge sys_clk_in);
         bit_clock_out = 1'b1;
         rx_byte[i] = serial_rx_output_in;
         repeat (HALF) @(negedge sys_clk_in);
      end
      // hold time over: the line no longer shows the last bit
      serial_tx_input_out = ~serial_tx_input_out;
   endtask
endmodule

// file: tb_fax_modem_host_interface.sv
// self-checking bench for the fax modem host interface
`timescale 1ns/1ps
module tb_fax_modem_host_interface;
   import fmhi_pkg::*;
   localparam int RDY = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic por_n = 1'b1;
   logic strap = 1'b0;
   logic cs_n = 1'b1;
   logic rd_p = 1'b1;
   logic wr_p = 1'b1;
   logic [4:0] rsel = 5'h00;
   logic [7:0] host_d = 8'h00;
   logic [7:0] status = 8'h00;
   logic tx_r = 1'b0;
   logic [7:0] rx_d = 8'h00;
   logic rx_v = 1'b0;
   logic [7:0] bus, hd_out, tx_d, got, v, r;
   logic oe_n, irq_n, irq_oe_n, bclk, txi, rxo, tx_v, rx_r, rdy;
   logic [7:0] mem [32];
   logic [7:0] q[$];
   logic [4:0] a;
   int seed;
   int n;
   int n_mismatch = 0;
   int checks_done = 0;

   always #2 clk = ~clk;
   assign bus = oe_n ? host_d : hd_out;

   fax_modem_host_interface #(.READY_CYCLES(RDY), .TX_FIFO_DEPTH(FIFO_DEPTH)) DUT (
      .sys_clk_in(clk), .rst_in(rst), .power_on_reset_n_in(por_n),
      .bus_style_strap_in(strap), .chip_select_n_in(cs_n), .read_pin_in(rd_p),
      .write_pin_in(wr_p), .register_select_lines_in(rsel), .host_data_lines_in(bus),
      .host_data_lines_out(hd_out), .host_data_lines_oe_n_out(oe_n), .irq_n_out(irq_n),
      .irq_oe_n_out(irq_oe_n), .bit_clock_in(bclk), .serial_tx_input_in(txi),
      .serial_rx_output_out(rxo), .modem_status_in(status), .tx_data_out(tx_d),
      .tx_valid_out(tx_v), .tx_ready_in(tx_r), .rx_data_in(rx_d), .rx_valid_in(rx_v),
      .rx_ready_out(rx_r), .ready_out(rdy));

   fmhi_terminal term (.sys_clk_in(clk), .serial_rx_output_in(rxo),
      .bit_clock_out(bclk), .serial_tx_input_out(txi));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic give_up;
      n_mismatch++;
      wrap_up;
   endtask

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one bus cycle held two clocks; sel low sends the strobes without chip select
   task automatic acc(input logic wr, input logic [4:0] ad, input logic [7:0] d,
                      input logic sel);
      @(negedge clk);
      cs_n = ~sel;
      rsel = ad;
      host_d = d;
      rd_p = strap | wr;
      wr_p = ~wr;
      repeat (2) @(negedge clk);
      got = hd_out;
      chk("bus drive", {7'h0, oe_n}, {7'h0, ~(sel & ~wr)});
      cs_n = 1'b1;
      rd_p = ~strap;
      wr_p = 1'b1;
      host_d = ~d;
      repeat (4) @(negedge clk);
      chk("bus float", {7'h0, oe_n}, 8'h01);
   endtask

   // takes one byte from the fifo, stalling before and after
   task automatic pull(input logic [7:0] exp);
      n = 0;
      while (tx_v !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 200) give_up;
      end
      chk("tx byte", tx_d, exp);
      tx_r = 1'b1;
      @(negedge clk);
      tx_r = 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      give_up;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = 85;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("ready", {7'h0, rdy}, 8'h00);
      repeat (RDY - 2) @(negedge clk);
      chk("ready", {7'h0, rdy}, 8'h00);
      repeat (4) @(negedge clk);
      chk("ready", {7'h0, rdy}, 8'h01);
      for (int s = 0; s < 2; s++) begin
         strap = s[0];
         rd_p = ~strap;
         for (int i = 0; i < 5; i++) begin
            a = 5'h07 + 5'(i * 6);
            v = 8'($random(seed));
            acc(1'b1, a, v, 1'b1);
            mem[a] = v;
            acc(1'b1, a, ~v, 1'b0);
            acc(1'b0, a, 8'h00, 1'b0);
            acc(1'b0, a, 8'h00, 1'b1);
            chk("register", got, mem[a]);
         end
      end
      strap = 1'b0;
      rd_p = 1'b1;
      acc(1'b1, REG_IRQ_ENABLE, 8'h00, 1'b1);
      status = 8'h01;
      repeat (4) @(negedge clk);
      chk("irq masked", {7'h0, irq_oe_n}, 8'h01);
      acc(1'b0, REG_CHANGE, 8'h00, 1'b1);
      chk("change flags", got, 8'h01);
      acc(1'b1, REG_IRQ_ENABLE, 8'h01, 1'b1);
      chk("irq pull", {6'h0, irq_n, irq_oe_n}, 8'h00);
      acc(1'b1, REG_CHANGE, 8'h01, 1'b1);
      chk("irq float", {6'h0, irq_n, irq_oe_n}, 8'h01);
      for (int m = 0; m < 2; m++) begin
         acc(1'b1, REG_CONTROL, 8'(m), 1'b1);
         rx_d = 8'($random(seed));
         v = 8'($random(seed));
         rx_v = 1'b1;
         n = 0;
         while (rx_r !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 100) give_up;
         end
         @(negedge clk);
         rx_v = 1'b0;
         rx_d = ~rx_d;
         term.frame(v, r);
         chk("rx byte", r, ~rx_d);
         if (m == 0)
            pull(v);
         else
            chk("tx ignored", {7'h0, tx_v}, 8'h00);
      end
      // fifo plus the one pending byte take 33; the last write is refused
      for (int i = 0; i < 34; i++) begin
         v = 8'($random(seed));
         acc(1'b1, REG_TX_BUF, v, 1'b1);
         if (q.size() < FIFO_DEPTH + 1)
            q.push_back(v);
      end
      acc(1'b0, REG_BUF_STATE, 8'h00, 1'b1);
      chk("buffer state", got & 8'h07, 8'h07);
      acc(1'b0, REG_RX_BUF, 8'h00, 1'b1);
      chk("rx buffer", got, ~rx_d);
      acc(1'b0, REG_BUF_STATE, 8'h00, 1'b1);
      chk("rx avail cleared", got & 8'h02, 8'h00);
      while (q.size() > 0)
         pull(q.pop_front());
      chk("tx empty", {7'h0, tx_v}, 8'h00);
      @(negedge clk);
      por_n = 1'b0;
      @(negedge clk);
      por_n = 1'b1;
      chk("ready", {7'h0, rdy}, 8'h00);
      acc(1'b0, 5'h1F, 8'h00, 1'b1);
      chk("after power reset", got, REG_RESET);
      wrap_up;
   end
endmodule
